// ===== rtl/gpcde_top.sv
// Three small parallel ports (5, 2 and 2 pins) behind an APB slave.
// Assumes APB on core_clk_i, sync active-high reset, pads outside.
//
// Overview of operation
// - Five-pin bidirectional port, one latch per pin, shared pins.
// - Five-pin latches are read/write; reset leaves them unchanged.
// - Direction bit 1 drives the pin, 0 makes it a Hi-Z input.
// - Clock enable drives bus clock on five-pin bit 2, overriding direction.
// - Reset clears five direction bits and the clock enable.
// - Five-pin read gives latch for outputs, pin level for inputs; bit 2 reads zero under clock out.
// - Latch writes accepted except bit 2 under clock out; input pins read back unchanged.
// - Two-pin timer port with read/write latches.
// - Reset clears both timer port direction bits.
// - Timer port read gives latch for outputs, pin for inputs.
// - Two-pin serial port with latches that reset leaves unchanged.
// - Reset clears both serial port direction bits.
// - Serial port read gives latch for outputs, pin for inputs.
// - Receive on serial bit 1, transmit on bit 0, alternate location selectable.
// - Serial module disabled returns serial pins to port control.
`timescale 1ns/1ps
module gpcde_top
   import gpcde_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Five-pin port
   input wire logic [C_W-1:0] pin_c_i,
   output logic [C_W-1:0] pin_c_o,
   output logic [C_W-1:0] pin_c_oe_o,
   // Timer port
   input wire logic [D_W-1:0] pin_d_i,
   output logic [D_W-1:0] pin_d_o,
   output logic [D_W-1:0] pin_d_oe_o,
   output logic [D_W-1:0] timer_in_o,
   // Serial port and alternate serial pins
   input wire logic [E_W-1:0] pin_e_i,
   output logic [E_W-1:0] pin_e_o,
   output logic [E_W-1:0] pin_e_oe_o,
   input wire logic alt_rxd_i,
   output logic alt_txd_o,
   output logic alt_txd_oe_o,
   // Serial module side
   input wire logic ser_txd_i,
   output logic ser_rxd_o
);
   logic [C_W-1:0] lat_c_q, lat_c_d, dir_c_q, dir_c_d, rd_c, lvl_c;
   logic [D_W-1:0] lat_d_q, lat_d_d, dir_d_q, dir_d_d, rd_d, lvl_d;
   logic [E_W-1:0] lat_e_q, lat_e_d, dir_e_q, dir_e_d, rd_e, lvl_e;
   logic clk_en_q, clk_en_d, ser_en_q, ser_en_d, ser_alt_q, ser_alt_d;
   logic [31:0] prdata_q, prdata_d;
   logic slverr_q, slverr_d;
   logic ser_rxd_q, ser_rxd_d, alt_rxd_lvl, ser_on;
   logic setup, access, wr, aligned, mapped;
   logic [5:0] idx;
   ////////////////////////////////////////////////////////////////////////
   // APB decode; zero wait states, data prepared in the setup cycle
   assign setup = psel_i & ~penable_i;
   assign access = psel_i & penable_i;
   assign wr = access & pwrite_i;
   assign idx = paddr_i[7:2];
   assign aligned = (paddr_i[1:0] == 2'h0);
   assign mapped = aligned & ((idx == IDX_C_DATA) | (idx == IDX_D_DATA) |
      (idx == IDX_E_DATA) | (idx == IDX_C_DIR) | (idx == IDX_D_DIR) |
      (idx == IDX_E_DIR) | (idx == IDX_SER_CFG));
   assign pready_o = 1'b1;
   assign pslverr_o = access & slverr_q;
   assign prdata_o = prdata_q;
   ////////////////////////////////////////////////////////////////////////
   // Register writes
   always_comb begin
      lat_c_d = lat_c_q;
      lat_d_d = lat_d_q;
      lat_e_d = lat_e_q;
      dir_c_d = dir_c_q;
      dir_d_d = dir_d_q;
      dir_e_d = dir_e_q;
      clk_en_d = clk_en_q;
      ser_en_d = ser_en_q;
      ser_alt_d = ser_alt_q;
      if (wr && aligned) begin
         case (idx)
            IDX_C_DATA: begin
               lat_c_d = pwdata_i[C_W-1:0];
               // bit 2 frozen under clock out
               if (clk_en_q) begin
                  lat_c_d[MCLK_PIN] = lat_c_q[MCLK_PIN];
               end
            end
            IDX_D_DATA: lat_d_d = pwdata_i[D_W-1:0];
            IDX_E_DATA: lat_e_d = pwdata_i[E_W-1:0];
            IDX_C_DIR: begin
               dir_c_d = pwdata_i[C_W-1:0];
               clk_en_d = pwdata_i[CLK_EN_BIT];
            end
            IDX_D_DIR: dir_d_d = pwdata_i[D_W-1:0];
            IDX_E_DIR: dir_e_d = pwdata_i[E_W-1:0];
            IDX_SER_CFG: begin
               ser_en_d = pwdata_i[SER_EN_BIT];
               ser_alt_d = pwdata_i[SER_ALT_BIT];
            end
            default: ;
         endcase
      end
   end
   always_ff @(posedge core_clk_i) begin
      lat_c_q <= lat_c_d;
      lat_d_q <= lat_d_d;
      lat_e_q <= lat_e_d;
   end
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         dir_c_q <= DIR_C_RST;
         clk_en_q <= CTRL_BIT_RST;
         dir_d_q <= DIR_DE_RST;
         dir_e_q <= DIR_DE_RST;
         ser_en_q <= CTRL_BIT_RST;
         ser_alt_q <= CTRL_BIT_RST;
      end else begin
         dir_c_q <= dir_c_d;
         clk_en_q <= clk_en_d;
         dir_d_q <= dir_d_d;
         dir_e_q <= dir_e_d;
         ser_en_q <= ser_en_d;
         ser_alt_q <= ser_alt_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Read data, captured in setup so prdata_o comes from a flop
   always_comb begin
      prdata_d = prdata_q;
      slverr_d = slverr_q;
      if (setup) begin
         prdata_d = 32'h0000_0000;
         slverr_d = ~mapped;
         if (!pwrite_i && aligned) begin
            case (idx)
               IDX_C_DATA: begin
                  prdata_d[C_W-1:0] = rd_c;
                  if (clk_en_q) begin
                     prdata_d[MCLK_PIN] = 1'b0;
                  end
               end
               IDX_D_DATA: prdata_d[D_W-1:0] = rd_d;
               IDX_E_DATA: prdata_d[E_W-1:0] = rd_e;
               IDX_C_DIR: begin
                  prdata_d[C_W-1:0] = dir_c_q;
                  prdata_d[CLK_EN_BIT] = clk_en_q;
               end
               IDX_D_DIR: prdata_d[D_W-1:0] = dir_d_q;
               IDX_E_DIR: prdata_d[E_W-1:0] = dir_e_q;
               IDX_SER_CFG: begin
                  prdata_d[SER_EN_BIT] = ser_en_q;
                  prdata_d[SER_ALT_BIT] = ser_alt_q;
               end
               default: ;
            endcase
         end
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         prdata_q <= 32'h0000_0000;
         slverr_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         slverr_q <= slverr_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Pins. Clock out is the raw bus clock; gated, so it can glitch: the enable
   // changes just after the rising edge, while the clock is high (it is a flop).
   // five-pin, timer and serial port cells
   genvar gi;
   generate
      for (gi = 0; gi < C_W; gi++) begin : g_c
         gpcde_pin u_pin (
            .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
            .pin_i(pin_c_i[gi]), .pin_o(pin_c_o[gi]),
            .pin_oe_o(pin_c_oe_o[gi]), .dir_i(dir_c_q[gi]),
            .latch_i(lat_c_q[gi]), .level_o(lvl_c[gi]), .rd_o(rd_c[gi]),
            .alt_en_i(clk_en_q && (gi == MCLK_PIN)),
            .alt_val_i(core_clk_i), .alt_oe_i(1'b1)
         );
      end
      for (gi = 0; gi < D_W; gi++) begin : g_d
         gpcde_pin u_pin (
            .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
            .pin_i(pin_d_i[gi]), .pin_o(pin_d_o[gi]),
            .pin_oe_o(pin_d_oe_o[gi]), .dir_i(dir_d_q[gi]),
            .latch_i(lat_d_q[gi]), .level_o(lvl_d[gi]), .rd_o(rd_d[gi]),
            .alt_en_i(1'b0), .alt_val_i(1'b0), .alt_oe_i(1'b0)
         );
      end
      for (gi = 0; gi < E_W; gi++) begin : g_e
         gpcde_pin u_pin (
            .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
            .pin_i(pin_e_i[gi]), .pin_o(pin_e_o[gi]),
            .pin_oe_o(pin_e_oe_o[gi]), .dir_i(dir_e_q[gi]),
            .latch_i(lat_e_q[gi]), .level_o(lvl_e[gi]), .rd_o(rd_e[gi]),
            // serial owns pins only while enabled
            .alt_en_i(ser_on), .alt_val_i(ser_txd_i), .alt_oe_i(gi == TXD_PIN)
         );
      end
   endgenerate
   assign timer_in_o = lvl_d;
   // serial pin mapping and alternate location
   assign ser_on = ser_en_q & ~ser_alt_q;
   assign alt_txd_o = ser_txd_i;
   assign alt_txd_oe_o = ser_en_q & ser_alt_q;
   gpcde_sync u_alt_rxd (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .async_i(alt_rxd_i), .sync_o(alt_rxd_lvl)
   );
   // Idle high when the receiver has no pin
   always_comb begin
      ser_rxd_d = 1'b1;
      if (ser_en_q) begin
         ser_rxd_d = ser_alt_q ? alt_rxd_lvl : lvl_e[RXD_PIN];
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         ser_rxd_q <= 1'b1;
      end else begin
         ser_rxd_q <= ser_rxd_d;
      end
   end
   assign ser_rxd_o = ser_rxd_q;
   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_rd_setup(logic [5:0] r);
      setup && !pwrite_i && aligned && (idx == r);
   endsequence
   sequence s_wr_access(logic [5:0] r);
      wr && aligned && (idx == r);
   endsequence
   property p_dir_c_reset;
      @(posedge core_clk_i)
      sys_rst_i |=> (dir_c_q == 5'h00) && !clk_en_q && (pin_c_oe_o == 5'h00);
   endproperty
   a_dir_c_reset: assert property (p_dir_c_reset)
      else $error("five-pin port not input after reset");
   property p_dir_d_reset;
      @(posedge core_clk_i) sys_rst_i |=> (pin_d_oe_o == 2'h0);
   endproperty
   a_dir_d_reset: assert property (p_dir_d_reset)
      else $error("timer port not input after reset");
   property p_dir_e_reset;
      @(posedge core_clk_i) sys_rst_i |=> (pin_e_oe_o == 2'h0);
   endproperty
   a_dir_e_reset: assert property (p_dir_e_reset)
      else $error("serial port not input after reset");
   property p_oe_dir;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      s_wr_access(IDX_D_DIR) |=> (pin_d_oe_o == $past(pwdata_i[1:0]));
   endproperty
   a_oe_dir: assert property (p_oe_dir)
      else $error("timer pin enable does not follow direction write");
   property p_clk_out;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      s_wr_access(IDX_C_DIR) ##1 clk_en_q |-> pin_c_oe_o[MCLK_PIN];
   endproperty
   a_clk_out: assert property (p_clk_out)
      else $error("clock pin not driven while clock out enabled");
   property p_wr_latch;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      s_wr_access(IDX_E_DATA) |=> (lat_e_q == $past(pwdata_i[1:0]));
   endproperty
   a_wr_latch: assert property (p_wr_latch)
      else $error("serial port latch write lost");
   property p_rd_c_zero;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      s_rd_setup(IDX_C_DATA) ##0 clk_en_q |=> !prdata_o[MCLK_PIN];
   endproperty
   a_rd_c_zero: assert property (p_rd_c_zero)
      else $error("clock pin bit not read as zero");
   property p_rd_c;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      s_rd_setup(IDX_C_DATA) ##0 (dir_c_q[0] == 1'b1)
         |=> (prdata_o[0] == $past(lat_c_q[0]));
   endproperty
   a_rd_c: assert property (p_rd_c)
      else $error("five-pin output bit does not read its latch");
   property p_rd_d;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      s_rd_setup(IDX_D_DATA) ##0 (dir_d_q == 2'h0)
         |=> (prdata_o[1:0] == $past(lvl_d));
   endproperty
   a_rd_d: assert property (p_rd_d)
      else $error("timer input pins do not read pin level");
   property p_rd_e;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      s_rd_setup(IDX_E_DATA) ##0 (dir_e_q == 2'h3)
         |=> (prdata_o[1:0] == $past(lat_e_q));
   endproperty
   a_rd_e: assert property (p_rd_e)
      else $error("serial output pins do not read latch");
   property p_release;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      !ser_en_q |-> (pin_e_oe_o == dir_e_q)
         && (((pin_e_o ^ lat_e_q) & dir_e_q) == 2'h0);
   endproperty
   a_release: assert property (p_release)
      else $error("serial pins not released to port");
   property p_txd_map;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      ser_on |-> pin_e_oe_o[TXD_PIN] && !pin_e_oe_o[RXD_PIN]
         && (pin_e_o[TXD_PIN] == ser_txd_i);
   endproperty
   a_txd_map: assert property (p_txd_map)
      else $error("serial transmit not mapped to bit 0");
endmodule // gpcde_top

// ===== rtl/gpcde_pkg.sv
// Constants shared by the three-port parallel I/O block.
// Assumes a 32-bit APB slave with register index = byte address / 4.
package gpcde_pkg;
   // Register indices; byte address is index times four
   localparam logic [5:0] IDX_C_DATA = 6'h02;
   localparam logic [5:0] IDX_D_DATA = 6'h03;
   localparam logic [5:0] IDX_E_DATA = 6'h08;
   localparam logic [5:0] IDX_C_DIR = 6'h06;
   localparam logic [5:0] IDX_D_DIR = 6'h07;
   localparam logic [5:0] IDX_E_DIR = 6'h0A;
   localparam logic [5:0] IDX_SER_CFG = 6'h0B;
   // Widths and field positions
   localparam int C_W = 5;
   localparam int D_W = 2;
   localparam int E_W = 2;
   localparam int MCLK_PIN = 2;
   localparam int CLK_EN_BIT = 7;
   localparam int SER_EN_BIT = 0;
   localparam int SER_ALT_BIT = 1;
   localparam int TXD_PIN = 0;
   localparam int RXD_PIN = 1;
   // Reset values of control state
   localparam logic [4:0] DIR_C_RST = 5'h00;
   localparam logic [1:0] DIR_DE_RST = 2'h0;
   localparam logic CTRL_BIT_RST = 1'b0;
endpackage

// ===== rtl/gpcde_sync.sv
// Two-flop synchroniser for one asynchronous pin level.
// Assumes sys_rst_i is synchronous to core_clk_i.
`timescale 1ns/1ps
module gpcde_sync (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Level
   input wire logic async_i,
   output logic sync_o
);
   logic meta_q, meta_d, sync_q, sync_d;

   always_comb begin
      meta_d = async_i;
      sync_d = meta_q;
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_o = sync_q;
endmodule // gpcde_sync

// ===== rtl/gpcde_pin.sv
// One bidirectional port pin: output select, enable and read mux.
// Assumes the pad resolves pin_o and pin_oe_o into the wire level.
`timescale 1ns/1ps
module gpcde_pin (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Pad side
   input wire logic pin_i,
   output logic pin_o,
   output logic pin_oe_o,
   // Register side
   input wire logic dir_i,
   input wire logic latch_i,
   // Alternate function takes the pin over
   input wire logic alt_en_i,
   input wire logic alt_val_i,
   input wire logic alt_oe_i,
   // Synchronised level and read value
   output logic level_o,
   output logic rd_o
);
   logic level;

   gpcde_sync u_sync (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(pin_i),
      .sync_o(level)
   );

   assign pin_o = alt_en_i ? alt_val_i : latch_i;
   assign pin_oe_o = alt_en_i ? alt_oe_i : dir_i;
   // Output pins read back the latch, inputs read the pin
   assign rd_o = dir_i ? latch_i : level;
   assign level_o = level;
endmodule // gpcde_pin

// ===== dv/gpcde_pad_model.sv
// Pad and board model: resolves each pin from core drive and outside level.
// Assumes the bench gives every pin an outside level at all times.
`timescale 1ns/1ps
module gpcde_pad_model #(
   parameter int W = 1
) (
   // Core side
   input wire logic [W-1:0] drv_i,
   input wire logic [W-1:0] oe_i,
   // Board side
   input wire logic [W-1:0] ext_i,
   output logic [W-1:0] lvl_o
);
   // Core buffer wins while enabled, board level otherwise
   always_comb begin
      for (int i = 0; i < W; i++) begin
         lvl_o[i] = oe_i[i] ? drv_i[i] : ext_i[i];
      end
   end
endmodule // gpcde_pad_model

// ===== dv/tb_top.sv
// Self-checking bench for the three-port parallel I/O block.
// Assumes zero-wait APB slave and two-flop pin synchronisers.
`timescale 1ns/1ps
module tb_top;
   import gpcde_pkg::*;
   logic core_clk, sys_rst, psel, penable, pwrite, ser_txd, alt_rxd;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err, alt_txd, alt_txd_oe, ser_rxd;
   logic [4:0] c_o, c_oe, c_lvl;
   logic [1:0] d_o, d_oe, d_lvl, e_o, e_oe, e_lvl, tmr;
   logic [8:0] ext;
   int fail_count, n_tests, cyc;
   wire logic [8:0] all_o = {e_o, d_o, c_o};
   wire logic [8:0] all_oe = {e_oe, d_oe, c_oe};
   gpcde_top i_dut (.core_clk_i(core_clk), .sys_rst_i(sys_rst),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .pin_c_i(c_lvl),
      .pin_c_o(c_o), .pin_c_oe_o(c_oe), .pin_d_i(d_lvl), .pin_d_o(d_o),
      .pin_d_oe_o(d_oe), .timer_in_o(tmr), .pin_e_i(e_lvl), .pin_e_o(e_o),
      .pin_e_oe_o(e_oe), .alt_rxd_i(alt_rxd), .alt_txd_o(alt_txd),
      .alt_txd_oe_o(alt_txd_oe), .ser_txd_i(ser_txd), .ser_rxd_o(ser_rxd));
   gpcde_pad_model #(.W(5)) i_pad_c (.drv_i(c_o), .oe_i(c_oe),
      .ext_i(ext[4:0]), .lvl_o(c_lvl));
   gpcde_pad_model #(.W(2)) i_pad_d (.drv_i(d_o), .oe_i(d_oe),
      .ext_i(ext[6:5]), .lvl_o(d_lvl));
   gpcde_pad_model #(.W(2)) i_pad_e (.drv_i(e_o), .oe_i(e_oe),
      .ext_i(ext[8:7]), .lvl_o(e_lvl));
   ////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // Hang guard, far above the few hundred cycles needed
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         close_out();
      end
   end
   task automatic close_out();
      if (fail_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // One APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle();
      repeat (4) @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////
   // Any direction setting on one port: outputs read latch, inputs read pin
   task automatic port_case(input logic [7:0] ad, input logic [7:0] ar,
      input int off, input logic [8:0] m, input logic [8:0] lat,
      input logic [8:0] pv, input logic [8:0] dir);
      apb(1'b1, ad, 32'(lat));
      ext <= (ext & ~(m << off)) | ((pv & m) << off);
      apb(1'b1, ar, 32'(dir));
      settle();
      apb(1'b0, ad, 32'h0);
      chk(rd, 32'(((lat & dir) | (pv & ~dir)) & m));
      apb(1'b0, ar, 32'h0);
      chk(rd, 32'(dir));
      chk(32'((all_oe >> off) & m), 32'(dir));
      chk(32'((all_o >> off) & m & dir), 32'(lat & dir));
   endtask
   task automatic reset_check();
      sys_rst <= 1'b1;
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
      chk(32'(all_oe), 32'h0);
      chk(32'(ser_rxd), 32'h1);
      apb(1'b0, 8'h18, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h1C, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h28, 32'h0);
      chk(rd, 32'h0);
   endtask
   // Latches survive reset: turn five-pin and serial ports to outputs and read them back
   task automatic latch_keep();
      apb(1'b1, 8'h18, 32'h1F);
      apb(1'b1, 8'h28, 32'h3);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h15);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h2);
      chk(32'(tmr), 32'(ext[6:5]));
   endtask
   task automatic clock_out();
      ext <= ext | 9'h004;
      apb(1'b1, 8'h18, 32'h80);
      @(posedge core_clk);
      chk(32'(c_oe), 32'h04);
      #5 chk(32'(c_o[2]), 32'h1);
      #12.5 chk(32'(c_o[2]), 32'h0);
      settle();
      apb(1'b0, 8'h08, 32'h0);
      chk(rd & 32'h4, 32'h0);
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h18, 32'h1F);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h04);
   endtask
   task automatic serial_route();
      apb(1'b1, 8'h28, 32'h0);
      apb(1'b1, 8'h2C, 32'h1);
      ser_txd <= 1'b0;
      ext <= ext & ~9'h100;
      settle();
      chk(32'({e_oe, e_o[0]}), 32'h2);
      chk(32'(ser_rxd), 32'h0);
      ser_txd <= 1'b1;
      ext <= ext | 9'h100;
      settle();
      chk(32'({e_o[0], ser_rxd}), 32'h3);
      apb(1'b1, 8'h2C, 32'h3);
      alt_rxd <= 1'b0;
      settle();
      chk(32'({alt_txd_oe, alt_txd, e_oe, ser_rxd}), 32'h18);
      apb(1'b1, 8'h2C, 32'h0);
      alt_rxd <= 1'b1;
      ext <= ext & ~9'h100;
      settle();
      chk(32'({alt_txd_oe, e_oe, ser_rxd}), 32'h1);
   endtask
   task automatic unmapped();
      apb(1'b0, 8'h3C, 32'h0);
      chk(rd, 32'h0);
      chk(32'(err), 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, ser_txd, alt_rxd} = 5'h03;
      paddr = 8'h00;
      pwdata = 32'h0;
      ext = 9'h0AA;
      fail_count = 0;
      n_tests = 0;
      cyc = 0;
      sys_rst = 1'b1;
      reset_check();
      port_case(8'h08, 8'h18, 0, 9'h1F, 9'h15, 9'h0A, 9'h00);
      port_case(8'h08, 8'h18, 0, 9'h1F, 9'h15, 9'h0A, 9'h13);
      port_case(8'h0C, 8'h1C, 5, 9'h03, 9'h01, 9'h02, 9'h00);
      port_case(8'h0C, 8'h1C, 5, 9'h03, 9'h01, 9'h02, 9'h01);
      port_case(8'h0C, 8'h1C, 5, 9'h03, 9'h02, 9'h02, 9'h03);
      port_case(8'h20, 8'h28, 7, 9'h03, 9'h02, 9'h01, 9'h02);
      port_case(8'h20, 8'h28, 7, 9'h03, 9'h02, 9'h01, 9'h00);
      reset_check();
      latch_keep();
      clock_out();
      serial_route();
      unmapped();
      close_out();
   end
endmodule // tb_top
